// ---- core/rbfs_pkg.sv ----
// Purpose: constants and types shared by the rail and self-test fault bank
// Assumes: register words sit at byte address four times their index
// Notes:   the bus decode compares word indices, never byte addresses
`default_nettype none
package rbfs_pkg;
    // word indices of the registers (byte address = index * 4)
    localparam logic [13:0] RAIL_IDX     = 14'h02a3; // supply_rail_faults
    localparam logic [13:0] OVUV_IDX     = 14'h02a4; // voltage_selftest_faults
    localparam logic [13:0] OTUT_IDX     = 14'h02a5; // temperature_selftest_faults
    localparam logic [13:0] RES_BASE_IDX = 14'h02b0; // correction result byte 0
    localparam logic [13:0] CTRL_IDX     = 14'h0300; // self-test control
    localparam logic [13:0] IRQ_STAT_IDX = 14'h0301; // interrupt status, w1c
    localparam logic [13:0] IRQ_MASK_IDX = 14'h0302; // interrupt mask

    // result byte store: bytes zero through eight
    localparam logic [3:0]  RES_COUNT    = 4'h9;
    localparam logic [9:0]  RES_PAD      = 10'h000;
    localparam int          RES_DEPTH    = 9;

    // supply_rail_faults bit positions
    localparam int RAIL_THERMISTOR_REFERENCE_OUTPUT_LOW  = 5; // thermistor_reference_low_flag
    localparam int RAIL_COMM_LOW   = 3; // comm_supply_low_flag
    localparam int RAIL_DIG_HIGH   = 2; // digital_supply_high_flag
    localparam int RAIL_ANA_HIGH   = 1; // analog_supply_high_flag

    // voltage_selftest_faults layout
    localparam logic [7:0] VBIST_FLAG_MASK = 8'h03; // comparator fail bits
    localparam logic [7:0] VBIST_RSVD_MASK = 8'hfc; // reserved, plain rw

    // control register bits
    localparam int CTRL_VBIST_EN = 0; // voltage_comparator_selftest enable
    localparam int CTRL_TBIST_EN = 1; // temperature_comparator_selftest enable
    localparam int CTRL_DIR      = 2; // test_direction_selector
    localparam logic [7:0] CTRL_MASK = 8'h07;

    // interrupt status bits
    localparam int IRQ_RAIL   = 0; // a rail flag newly set
    localparam int IRQ_VBIST  = 1; // a voltage self-test flag newly set
    localparam int IRQ_TBIST  = 2; // a temperature self-test flag newly set
    localparam int IRQ_RESULT = 3; // a result byte was written
    localparam logic [7:0] IRQ_MASK_BITS = 8'h0f;

    // reset values
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // bus slave sequencing
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WAIT,
        BUS_ACK
    } rbfs_bus_state_t;
endpackage : rbfs_pkg
`default_nettype wire

// ---- core/rbfs_mem_if.sv ----
// Purpose: link between the fault bank and its result byte store
// Assumes: both ends run on the same clock
// Notes:   read data is registered inside the store, one cycle behind rd_idx
`timescale 1ns/1ps
`default_nettype none
interface rbfs_mem_if;
    logic       wr_en;   // write strobe from the coding engine
    logic [3:0] wr_idx;  // byte being written
    logic [7:0] wr_data; // value written
    logic [3:0] rd_idx;  // byte selected by the bus
    logic [7:0] rd_data; // registered read data

    // bank side drives requests
    modport ctrl (output wr_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
    // store side answers
    modport mem  (input wr_en, input wr_idx, input wr_data,
                  input rd_idx, output rd_data);
endinterface : rbfs_mem_if
`default_nettype wire

// ---- core/rbfs_result_mem.sv ----
// Purpose: read-only (to software) store of the coding self-test results
// Assumes: writes come only from the coding engine on the same clock
// Notes:   read data leaves a register, so reads cost one cycle
`timescale 1ns/1ps
`default_nettype none
module rbfs_result_mem (
    input  wire logic clk_i,    // system clock
    input  wire logic rst_i,    // synchronous reset, high
    rbfs_mem_if.mem   mem       // request and answer bundle
);
    // one byte per result slot, all clear after reset
    logic [7:0] bytes [rbfs_pkg::RES_DEPTH];

    // per-slot storage, one generate loop
    genvar gi;
    generate
        for (gi = 0; gi < rbfs_pkg::RES_DEPTH; gi = gi + 1) begin : g_slot
            // this slot's write decode
            wire hit = mem.wr_en && (mem.wr_idx == 4'(gi));
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    bytes[gi] <= rbfs_pkg::BYTE_ZERO;
                end else if (hit) begin
                    bytes[gi] <= mem.wr_data;
                end
            end
        end
    endgenerate

    // out-of-range slots read as zero rather than x
    wire        rd_ok   = mem.rd_idx < rbfs_pkg::RES_COUNT;
    wire [7:0]  rd_pick = rd_ok ? bytes[mem.rd_idx] : rbfs_pkg::BYTE_ZERO;

    // registered read port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem.rd_data <= rbfs_pkg::BYTE_ZERO;
        end else begin
            mem.rd_data <= rd_pick;
        end
    end
endmodule : rbfs_result_mem
`default_nettype wire

// ---- core/rbfs_fault_bank.sv ----
// Purpose: rail and self-test fault status bank behind a wishbone slave
// Assumes: fault levels arrive from analog blocks, asynchronous to clk_i
// Notes:   flags are sticky and cleared by writing one; set beats clear
//
// Functional notes
// - thermistor reference undervoltage sets its flag
// - comm supply undervoltage sets its flag
// - digital supply overvoltage sets its flag
// - analog supply overvoltage sets its flag
// - voltage comparator fails flagged only when enabled
// - six channel fail flags, only when enabled
// - direction zero: software reads result bytes 0-7
// - direction one: software reads result bytes 0-8
// - further result bytes at consecutive read-only addresses
`timescale 1ns/1ps
`default_nettype none
module rbfs_fault_bank (
    input  wire logic        clk_i,         // 50 MHz system clock
    input  wire logic        rst_i,         // synchronous reset, high
    input  wire logic [15:0] adr_i,         // wishbone byte address
    input  wire logic [31:0] dat_i,         // wishbone write data
    input  wire logic [3:0]  sel_i,         // wishbone byte selects
    input  wire logic        we_i,          // wishbone write enable
    input  wire logic        cyc_i,         // wishbone cycle
    input  wire logic        stb_i,         // wishbone strobe
    output logic      [31:0] dat_o,         // wishbone read data
    output logic             ack_o,         // wishbone acknowledge
    output logic             irq_o,         // level interrupt
    input  wire logic [7:0]  rail_raw_i,    // raw supply_rail_faults levels
    input  wire logic [1:0]  vcomp_raw_i,   // raw high/low comparator fails
    input  wire logic [7:0]  tcomp_raw_i,   // raw channel and comparator fails
    input  wire logic        result_wr_i,   // coding engine result strobe
    input  wire logic [3:0]  result_idx_i,  // result byte index
    input  wire logic [7:0]  result_data_i, // result byte value
    output logic             vbist_en_o,    // voltage self-test enable
    output logic             tbist_en_o,    // temperature self-test enable
    output logic             test_dir_o     // test_direction_selector
);
    // two-stage synchronisers for all analog fault levels
    // a level caught mid-change may settle either way; flop two hides it
    logic [17:0] sync_a;            // first stage, read by sync_b only
    logic [17:0] sync_b;            // second stage, safe to use
    wire  [17:0] raw_all = {tcomp_raw_i, vcomp_raw_i, rail_raw_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 18'h0_0000;
            sync_b <= 18'h0_0000;
        end else begin
            sync_a <= raw_all;
            sync_b <= sync_a;
        end
    end

    // synchronised views
    wire [7:0] rail_sync  = sync_b[7:0];
    wire [1:0] vcomp_sync = sync_b[9:8];
    wire [7:0] tcomp_sync = sync_b[17:10];

    // register state
    logic [7:0] rail;               // supply_rail_faults
    logic [7:0] ovuv;               // voltage_selftest_faults
    logic [7:0] otut;               // temperature_selftest_faults
    logic [7:0] ctrl;               // self-test control
    logic [3:0] irq_stat;           // sticky interrupt events
    logic [3:0] irq_mask;           // interrupt enables
    rbfs_pkg::rbfs_bus_state_t state;
    rbfs_pkg::rbfs_bus_state_t next_state;

    // bus decode
    wire [13:0] word_idx = adr_i[15:2];
    wire        req      = cyc_i & stb_i;
    wire [13:0] res_off  = word_idx - rbfs_pkg::RES_BASE_IDX;
    wire        hit_rail = word_idx == rbfs_pkg::RAIL_IDX;
    wire        hit_ovuv = word_idx == rbfs_pkg::OVUV_IDX;
    wire        hit_otut = word_idx == rbfs_pkg::OTUT_IDX;
    wire        hit_ctrl = word_idx == rbfs_pkg::CTRL_IDX;
    wire        hit_stat = word_idx == rbfs_pkg::IRQ_STAT_IDX;
    wire        hit_mask = word_idx == rbfs_pkg::IRQ_MASK_IDX;
    // result bytes sit at consecutive words after byte zero
    wire        hit_res  = (word_idx >= rbfs_pkg::RES_BASE_IDX) &&
                           (res_off < {rbfs_pkg::RES_PAD,
                                       rbfs_pkg::RES_COUNT});

    // a write lands on the edge where the master sees ack
    wire        commit   = (state == rbfs_pkg::BUS_ACK) & req & we_i & sel_i[0];
    wire [7:0]  wbyte    = dat_i[7:0];

    // per-register write-one-to-clear masks
    wire [7:0] rail_clr = (commit & hit_rail) ? wbyte : rbfs_pkg::BYTE_ZERO;
    wire [7:0] ovuv_clr = (commit & hit_ovuv) ? wbyte : rbfs_pkg::BYTE_ZERO;
    wire [7:0] otut_clr = (commit & hit_otut) ? wbyte : rbfs_pkg::BYTE_ZERO;
    wire [7:0] stat_clr = (commit & hit_stat) ? wbyte : rbfs_pkg::BYTE_ZERO;

    // control fields steer flag gating
    wire vbist_en = ctrl[rbfs_pkg::CTRL_VBIST_EN];
    wire tbist_en = ctrl[rbfs_pkg::CTRL_TBIST_EN];

    // set terms; self-test flags gated by their enables
    wire [7:0] rail_set = rail_sync;
    wire [7:0] ovuv_set = {6'h00, vcomp_sync & {2{vbist_en}}};
    wire [7:0] otut_set = tcomp_sync & {8{tbist_en}};

    // sticky update: set wins over a same-cycle clear
    wire [7:0] next_rail = rail_set | (rail & ~rail_clr);
    wire [7:0] next_otut = otut_set | (otut & ~otut_clr);
    wire [7:0] ovuv_flag = ovuv_set |
                           (ovuv & rbfs_pkg::VBIST_FLAG_MASK & ~ovuv_clr);
    // reserved upper bits are plain storage
    wire [7:0] ovuv_rsvd = (commit & hit_ovuv) ?
                           (wbyte & rbfs_pkg::VBIST_RSVD_MASK) :
                           (ovuv & rbfs_pkg::VBIST_RSVD_MASK);
    wire [7:0] next_ovuv = ovuv_rsvd | ovuv_flag;

    // interrupt events: a flag rising from clear, or a result byte write
    wire [3:0] irq_ev = {result_wr_i,
                         |(otut_set & ~otut),
                         |(ovuv_set & ~ovuv),
                         |(rail_set & ~rail)};
    wire [3:0] next_stat = irq_ev | (irq_stat & ~stat_clr[3:0]);

    // fault register updates
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rail <= rbfs_pkg::BYTE_ZERO;
            ovuv <= rbfs_pkg::BYTE_ZERO;
            otut <= rbfs_pkg::BYTE_ZERO;
        end else begin
            rail <= next_rail;
            ovuv <= next_ovuv;
            otut <= next_otut;
        end
    end

    // control and interrupt registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= rbfs_pkg::BYTE_ZERO;
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
            irq_o    <= 1'b0;
        end else begin
            if (commit & hit_ctrl) begin
                ctrl <= wbyte & rbfs_pkg::CTRL_MASK;
            end
            if (commit & hit_mask) begin
                irq_mask <= wbyte[3:0];
            end
            irq_stat <= next_stat;
            // the pin trails the status by a cycle so it leaves a flop
            irq_o    <= |(irq_stat & irq_mask);
        end
    end

    // control bits also leave as flop outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vbist_en_o <= 1'b0;
            tbist_en_o <= 1'b0;
            test_dir_o <= 1'b0;
        end else begin
            vbist_en_o <= vbist_en;
            tbist_en_o <= tbist_en;
            test_dir_o <= ctrl[rbfs_pkg::CTRL_DIR];
        end
    end

    // result store; software can only read it
    rbfs_mem_if mem_bus ();
    assign mem_bus.wr_en   = result_wr_i;
    assign mem_bus.wr_idx  = result_idx_i;
    assign mem_bus.wr_data = result_data_i;
    assign mem_bus.rd_idx  = res_off[3:0];

    rbfs_result_mem u_result_mem (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .mem   (mem_bus.mem)
    );

    // read mux; unmapped words read as zero
    wire [7:0] rd_byte = hit_rail ? rail :
                         hit_ovuv ? ovuv :
                         hit_otut ? otut :
                         hit_res  ? mem_bus.rd_data :
                         hit_ctrl ? ctrl :
                         hit_stat ? {4'h0, irq_stat} :
                         hit_mask ? {4'h0, irq_mask} :
                         rbfs_pkg::BYTE_ZERO;

    // bus sequencing: idle, one wait for the memory, then ack
    // the wait lets the result store register its read data, so every
    // address answers with the same fixed latency
    always_comb begin
        next_state = state;
        case (state)
            rbfs_pkg::BUS_IDLE: begin
                if (req) begin
                    next_state = rbfs_pkg::BUS_WAIT;
                end
            end
            rbfs_pkg::BUS_WAIT: begin
                next_state = rbfs_pkg::BUS_ACK;
            end
            rbfs_pkg::BUS_ACK: begin
                next_state = rbfs_pkg::BUS_IDLE;
            end
            default: begin
                next_state = rbfs_pkg::BUS_IDLE;
            end
        endcase
    end

    // state, ack and read data registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= rbfs_pkg::BUS_IDLE;
            ack_o <= 1'b0;
            dat_o <= rbfs_pkg::WORD_ZERO;
        end else begin
            state <= next_state;
            ack_o <= (next_state == rbfs_pkg::BUS_ACK);
            if (state == rbfs_pkg::BUS_WAIT) begin
                dat_o <= {24'h00_0000, rd_byte};
            end
        end
    end

    // local copies of bit positions, declared before the checks use them
    localparam int RAIL_THERMISTOR_REFERENCE_OUTPUT_LOW_C = rbfs_pkg::RAIL_THERMISTOR_REFERENCE_OUTPUT_LOW;
    localparam int RAIL_COMM_LOW_C  = rbfs_pkg::RAIL_COMM_LOW;
    localparam int RAIL_DIG_HIGH_C  = rbfs_pkg::RAIL_DIG_HIGH;
    localparam int RAIL_ANA_HIGH_C  = rbfs_pkg::RAIL_ANA_HIGH;

    // checks; reset disables them all
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_thermistor_reference_output_low_sets: assert property (
        sync_b[RAIL_THERMISTOR_REFERENCE_OUTPUT_LOW_C] |=> rail[RAIL_THERMISTOR_REFERENCE_OUTPUT_LOW_C])
        else $error("reference low flag not set");
    a_comm_low_sets: assert property (
        sync_b[RAIL_COMM_LOW_C] |=> rail[RAIL_COMM_LOW_C])
        else $error("comm supply low flag not set");
    a_dig_high_sets: assert property (
        sync_b[RAIL_DIG_HIGH_C] |=> rail[RAIL_DIG_HIGH_C])
        else $error("digital supply high flag not set");
    a_ana_high_sets: assert property (
        sync_b[RAIL_ANA_HIGH_C] ##1 !rail_clr[RAIL_ANA_HIGH_C]
            ##1 !rail_clr[RAIL_ANA_HIGH_C]
            |-> rail[RAIL_ANA_HIGH_C] [*2])
        else $error("analog supply high flag not held");
    a_vbist_gated: assert property (
        (|(ovuv[1:0] & ~$past(ovuv[1:0]))) |-> $past(vbist_en))
        else $error("voltage self-test flag set while disabled");
    a_tbist_channel: assert property (
        (tbist_en && tcomp_sync[7]) |=> otut[7])
        else $error("channel six fail flag not set");
    a_tbist_gated: assert property (
        (|(otut & ~$past(otut))) |-> $past(tbist_en))
        else $error("temperature self-test flag set while disabled");
    a_result_read: assert property (
        (state == rbfs_pkg::BUS_WAIT && hit_res && req)
            |=> ack_o && dat_o[7:0] == $past(mem_bus.rd_data))
        else $error("result byte read mismatch");
    a_flags_sticky: assert property (
        (rail_clr == rbfs_pkg::BYTE_ZERO && otut_clr == rbfs_pkg::BYTE_ZERO)
            |=> ((rail & $past(rail)) == $past(rail)) &&
                ((otut & $past(otut)) == $past(otut)))
        else $error("fault flag dropped without a clear");
    a_ack_timing: assert property (
        (state == rbfs_pkg::BUS_IDLE && req) |=> !ack_o ##1 ack_o ##1 !ack_o)
        else $error("ack not on the second edge");
    a_irq_level: assert property (
        irq_o == $past(|(irq_stat & irq_mask)))
        else $error("interrupt level mismatch");
    a_vbist_sets: assert property (
        (vbist_en && vcomp_sync[1]) |=> ovuv[1])
        else $error("high comparator fail flag not set");
    a_tbist_first: assert property (
        (tbist_en && tcomp_sync[2]) |=> otut[2])
        else $error("channel one fail flag not set");
    a_rail_event: assert property (
        (|(rail_set & ~rail)) |=> irq_stat[rbfs_pkg::IRQ_RAIL])
        else $error("rail event missed in interrupt status");
    a_rsvd_storage: assert property (
        (commit && hit_ovuv)
            |=> (ovuv & rbfs_pkg::VBIST_RSVD_MASK) ==
                ($past(wbyte) & rbfs_pkg::VBIST_RSVD_MASK))
        else $error("reserved voltage bits not stored");
    a_dir_copy: assert property (
        test_dir_o == $past(ctrl[rbfs_pkg::CTRL_DIR]))
        else $error("direction output not a copy of control");

    // covers: the scenarios the bench is meant to reach
    c_result_read: cover property (
        state == rbfs_pkg::BUS_ACK && hit_res && !we_i);
    c_rail_clear: cover property (commit && hit_rail && rail != 8'h00);
    c_irq_rise: cover property ($rose(irq_o));
    c_set_beats_clear: cover property (|(rail_set & rail_clr));
    c_vbist_flag: cover property ($rose(ovuv[1]));
endmodule : rbfs_fault_bank
`default_nettype wire

// ---- sim/rbfs_fault_bank_tb_top.sv ----
// Purpose: self-checking bench for the rail and self-test fault bank
// Assumes: fault levels pass the two sync flops well within five cycles
// Notes:   wishbone classic master, one idle cycle between transfers
`timescale 1ns/1ps
`default_nettype none
module rbfs_fault_bank_tb_top;
    logic        clk_i;         // 50 MHz bench clock
    logic        rst_i;         // synchronous reset, high
    logic [15:0] adr_i;         // byte address
    logic [31:0] dat_i;         // write data
    logic [3:0]  sel_i;         // byte selects
    logic        we_i;          // write enable
    logic        cyc_i;         // cycle
    logic        stb_i;         // strobe
    logic [31:0] dat_o;         // read data
    logic        ack_o;         // acknowledge
    logic        irq_o;         // level interrupt
    logic [7:0]  rail_raw_i;    // raw rail faults
    logic [1:0]  vcomp_raw_i;   // raw voltage comparator fails
    logic [7:0]  tcomp_raw_i;   // raw channel and comparator fails
    logic        result_wr_i;   // result byte strobe
    logic [3:0]  result_idx_i;  // result byte index
    logic [7:0]  result_data_i; // result byte value
    logic        vbist_en_o;    // voltage self-test enable
    logic        tbist_en_o;    // temperature self-test enable
    logic        test_dir_o;    // direction selector copy
    int          mismatches;    // failed comparisons
    int          checks_done;   // comparisons made

    // one row: raw levels and control in, flags expected out
    typedef struct {
        logic [7:0] rail, tc, ctrl, e_rail, e_vb, e_tb;
        logic [1:0] vc;
    } rbfs_row_t;
    rbfs_row_t rows [8];

    rbfs_fault_bank dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .rail_raw_i(rail_raw_i), .vcomp_raw_i(vcomp_raw_i),
        .tcomp_raw_i(tcomp_raw_i), .result_wr_i(result_wr_i),
        .result_idx_i(result_idx_i), .result_data_i(result_data_i),
        .vbist_en_o(vbist_en_o), .tbist_en_o(tbist_en_o),
        .test_dir_o(test_dir_o));

    // free-running clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // counts printed, then the verdict
    task automatic give_verdict();
        $display("mismatches %0d, checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check

    // one classic cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [13:0] idx,
                       input logic [7:0] wd, input logic [3:0] sel,
                       output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h00_0000, wd};
        sel_i <= sel;
        n = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        // a missing ack ends the run
        if (n >= 20) begin
            mismatches++;
            give_verdict();
        end
    endtask : bus

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, 4'h1, x);
    endtask : wr

    task automatic rd_chk(input logic [13:0] idx, input logic [7:0] e);
        logic [31:0] x;
        bus(1'b0, idx, 8'h00, 4'hf, x);
        check(x, {24'h00_0000, e});
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // raw levels up for five cycles, then gone again
    task automatic pulse_raw(input logic [7:0] r, input logic [1:0] v,
                             input logic [7:0] t);
        rail_raw_i  <= r;
        vcomp_raw_i <= v;
        tcomp_raw_i <= t;
        tick(5);
        rail_raw_i  <= 8'h00;
        vcomp_raw_i <= 2'h0;
        tcomp_raw_i <= 8'h00;
        tick(5);
    endtask : pulse_raw

    task automatic put_result(input logic [3:0] i, input logic [7:0] d);
        @(posedge clk_i);
        result_wr_i   <= 1'b1;
        result_idx_i  <= i;
        result_data_i <= d;
        @(posedge clk_i);
        result_wr_i   <= 1'b0;
    endtask : put_result

    // main sequence
    initial begin
        {adr_i, dat_i, sel_i, we_i, cyc_i, stb_i} = '0;
        {rail_raw_i, vcomp_raw_i, tcomp_raw_i} = '0;
        {result_wr_i, result_idx_i, result_data_i} = '0;
        mismatches = 0;
        checks_done = 0;
        // rail flags first; then disabled self-tests must ignore their fails, enabled ones flag them
        rows = '{'{8'h20,8'h00,8'h00,8'h20,8'h00,8'h00,2'h0},
                 '{8'h08,8'h00,8'h00,8'h08,8'h00,8'h00,2'h0},
                 '{8'h04,8'h00,8'h00,8'h04,8'h00,8'h00,2'h0},
                 '{8'h02,8'h00,8'h00,8'h02,8'h00,8'h00,2'h0},
                 '{8'h00,8'hff,8'h00,8'h00,8'h00,8'h00,2'h3},
                 '{8'h00,8'hfc,8'h02,8'h00,8'h00,8'hfc,2'h2},
                 '{8'h00,8'h03,8'h01,8'h00,8'h03,8'h00,2'h3},
                 '{8'h00,8'h80,8'h07,8'h00,8'h01,8'h80,2'h1}};
        rst_i = 1'b1;
        tick(3);
        rst_i <= 1'b0;
        for (int i = 0; i < 3; i++) rd_chk(14'h02a3 + 14'(i), 8'h00);
        rd_chk(rbfs_pkg::RES_BASE_IDX, 8'h00);
        check(32'(irq_o), 32'h0000_0000);
        foreach (rows[i]) begin
            wr(rbfs_pkg::CTRL_IDX, rows[i].ctrl);
            tick(2);
            check(32'({test_dir_o, tbist_en_o, vbist_en_o}),
                  32'(rows[i].ctrl[2:0]));
            pulse_raw(rows[i].rail, rows[i].vc, rows[i].tc);
            rd_chk(rbfs_pkg::RAIL_IDX, rows[i].e_rail);
            rd_chk(rbfs_pkg::OVUV_IDX, rows[i].e_vb);
            rd_chk(rbfs_pkg::OTUT_IDX, rows[i].e_tb);
            wr(rbfs_pkg::RAIL_IDX, 8'hff);
            wr(rbfs_pkg::OVUV_IDX, 8'h03);
            wr(rbfs_pkg::OTUT_IDX, 8'hff);
            for (int k = 0; k < 3; k++) rd_chk(14'h02a3 + 14'(k), 8'h00);
        end
        // clear while the fault still stands: set wins
        rail_raw_i <= 8'h20;
        tick(5);
        wr(rbfs_pkg::RAIL_IDX, 8'hff);
        rd_chk(rbfs_pkg::RAIL_IDX, 8'h20);
        pulse_raw(8'h00, 2'h0, 8'h00);
        wr(rbfs_pkg::RAIL_IDX, 8'hff);
        rd_chk(rbfs_pkg::RAIL_IDX, 8'h00);
        // reserved voltage bits are plain storage beside the flags
        wr(rbfs_pkg::OVUV_IDX, 8'hfc);
        rd_chk(rbfs_pkg::OVUV_IDX, 8'hfc);
        wr(rbfs_pkg::OVUV_IDX, 8'h00);
        // low byte not selected: control keeps all three bits
        begin
            logic [31:0] x;
            bus(1'b1, rbfs_pkg::CTRL_IDX, 8'h00, 4'he, x);
        end
        rd_chk(rbfs_pkg::CTRL_IDX, 8'h07);
        // encoder direction: bytes zero through eight
        for (int i = 0; i < 9; i++) put_result(4'(i), 8'(17 * (i + 1)));
        check(32'(test_dir_o), 32'h0000_0001);
        for (int i = 0; i < 9; i++) rd_chk(rbfs_pkg::RES_BASE_IDX + 14'(i), 8'(17 * (i + 1)));
        // decoder direction: bytes zero through seven
        wr(rbfs_pkg::CTRL_IDX, 8'h00);
        tick(2);
        check(32'(test_dir_o), 32'h0000_0000);
        for (int i = 0; i < 8; i++) rd_chk(rbfs_pkg::RES_BASE_IDX + 14'(i), 8'(17 * (i + 1)));
        // result bytes refuse bus writes; past the last byte reads zero
        wr(rbfs_pkg::RES_BASE_IDX, 8'haa);
        rd_chk(rbfs_pkg::RES_BASE_IDX, 8'h11);
        rd_chk(rbfs_pkg::RES_BASE_IDX + 14'h0009, 8'h00);
        rd_chk(14'h0010, 8'h00);
        // interrupt: raise, masked, unmasked, cleared
        wr(rbfs_pkg::IRQ_STAT_IDX, 8'h0f);
        rd_chk(rbfs_pkg::IRQ_STAT_IDX, 8'h00);
        put_result(4'h0, 8'h5a);
        tick(2);
        rd_chk(rbfs_pkg::IRQ_STAT_IDX, 8'h08);
        check(32'(irq_o), 32'h0000_0000);
        wr(rbfs_pkg::IRQ_MASK_IDX, 8'h08);
        tick(2);
        check(32'(irq_o), 32'h0000_0001);
        rd_chk(rbfs_pkg::IRQ_MASK_IDX, 8'h08);
        wr(rbfs_pkg::IRQ_STAT_IDX, 8'h08);
        tick(2);
        check(32'(irq_o), 32'h0000_0000);
        // second reset in mid-run wipes flags, results and enables
        wr(rbfs_pkg::CTRL_IDX, 8'h07);
        pulse_raw(8'h08, 2'h0, 8'h00);
        rd_chk(rbfs_pkg::RAIL_IDX, 8'h08);
        rd_chk(rbfs_pkg::IRQ_STAT_IDX, 8'h01);
        @(posedge clk_i);
        rst_i <= 1'b1;
        tick(3);
        rst_i <= 1'b0;
        rd_chk(rbfs_pkg::RAIL_IDX, 8'h00);
        rd_chk(rbfs_pkg::RES_BASE_IDX + 14'h0008, 8'h00);
        check(32'({test_dir_o, tbist_en_o, vbist_en_o}), 32'h0000_0000);
        give_verdict();
    end
endmodule : rbfs_fault_bank_tb_top
`default_nettype wire
